// ### rtl/ofi_map.svh
// ofi_map.svh: offsets, field positions, codes and timing counts for the
// connection-request and identification framer.
// assumes: included by the package and the framer; definitions only.
`ifndef OFI_MAP_SVH
`define OFI_MAP_SVH

`define OFI_FRAME_BYTES 32
`define OFI_AFT_IDENTIFY 4'h0
`define OFI_AFT_OPEN 4'h1
`define OFI_PROTO_SMP 2'h0
`define OFI_PROTO_SSP 2'h1
`define OFI_PROTO_STP 2'h2
`define OFI_PROTO_RSVD 2'h3
`define OFI_RATE_1G5 4'h0
`define OFI_RATE_3G0 4'h1
`define OFI_TAG_NONE 16'hffff
`define OFI_BYTE_TYPE 0
`define OFI_BYTE_RATE 1
`define OFI_BYTE_TAG 2
`define OFI_BYTE_WAIT 10
`define OFI_BYTE_DEST 12
`define OFI_BYTE_SRC 20
`define OFI_BYTE_ID_PHY 1
`define OFI_BYTE_ID_RATE 2
`define OFI_BYTE_ID_CAPS 3
`define OFI_BIT_INIT 7
`define OFI_BIT_SCALE 7
`define OFI_WAIT_MAX 15'h7fff
`define OFI_US_PER_MS 1000
`define OFI_CLK_MHZ 125
`define OFI_US_DIV_DEFAULT 125
`define OFI_ID_TIMEOUT_US 1000
`define OFI_ID_RETRIES 1
`define OFI_NUM_PHYS 4

`endif

// ### rtl/ofi_pkg.sv
// ofi_pkg.sv: types shared by the framer and its surroundings.
// assumes: ofi_map.svh sits on the include path.
`include "ofi_map.svh"

package ofi_pkg;

  typedef logic [63:0] ofi_name_t;

  // fields of a connection request, as built or as decoded
  typedef struct packed {
    logic initiator;
    logic [1:0] protocol;
    logic [3:0] linkRate;
    logic [15:0] connTag;
    logic scale;
    logic [14:0] waitTime;
    ofi_name_t destName;
    ofi_name_t srcName;
  } ofi_open_s;

  // fields of an identification frame that the exchange needs
  typedef struct packed {
    logic [7:0] phyId;
    logic [3:0] maxRate;
    logic [7:0] caps;
    ofi_name_t devName;
  } ofi_ident_s;

  typedef enum logic [2:0] {
    OFI_TX_IDLE = 3'b000,
    OFI_TX_SOAF = 3'b001,
    OFI_TX_DATA = 3'b010,
    OFI_TX_EOAF = 3'b011
  } ofi_tx_e;

  typedef enum logic [1:0] {
    OFI_ID_OFF = 2'b00,
    OFI_ID_WAIT = 2'b01,
    OFI_ID_DONE = 2'b10,
    OFI_ID_FAIL = 2'b11
  } ofi_id_e;

endpackage

// ### rtl/ofi_framer.sv
// ofi_framer.sv: builds and parses connection-request and identification
// address frames, runs the identification exchange, groups phys into ports.
// assumes: CRC, scrambling and primitive coding sit outside; the link layer
// marks start/end of a received frame and reports the CRC result at its end.
`timescale 1ns/10ps
`include "ofi_map.svh"

module ofi_framer #(
  parameter int US_DIV = `OFI_US_DIV_DEFAULT,
  parameter int ID_TIMEOUT_US = `OFI_ID_TIMEOUT_US,
  parameter int PHY_INDEX = 0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // local identity and roles
  input wire ofi_pkg::ofi_ident_s localIdent,
  input wire logic roleInitiator,
  input wire logic roleTarget,
  // phy and connection state
  input wire logic phyResetDone,
  input wire logic connOpen,
  // connection request from port control
  input wire logic openReq,
  input wire ofi_pkg::ofi_open_s openFields,
  input wire logic tagNeeded,
  input wire logic [15:0] tagForTarget,
  input wire logic tagFromInitiator,
  input wire logic [15:0] tagLastRcvd,
  output logic openBusy,
  output logic openSent,
  // transmit byte stream to the link layer
  output logic txSoaf,
  output logic txEoaf,
  output logic txValid,
  output logic [7:0] txByte,
  input wire logic txReady,
  // receive byte stream from the link layer
  input wire logic rxSoaf,
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  input wire logic rxEoaf,
  input wire logic rxCrcOk,
  // decoded results
  output logic rxIdentValid,
  output ofi_pkg::ofi_ident_s rxIdent,
  output logic rxOpenValid,
  output ofi_pkg::ofi_open_s rxOpen,
  output logic rejectProtocol,
  output logic [15:0] rxTagLatest,
  output logic connAsInitiator,
  // identification status and grouping
  input wire ofi_pkg::ofi_name_t [`OFI_NUM_PHYS-1:0] peerNames,
  input wire logic [`OFI_NUM_PHYS-1:0] peerNamesValid,
  output logic identDone,
  output logic phyResetRestart,
  output logic [`OFI_NUM_PHYS-1:0] samePortMask
);

  localparam int US_DIV_CNT = (US_DIV < 1) ? 1 : US_DIV;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    ofi_pkg::ofi_tx_e txState;
    logic [4:0] txIdx;
    logic [255:0] txBuf;
    logic txIsOpen;
    logic openPend;
    logic identPend;
    logic openSent;
    ofi_pkg::ofi_id_e idState;
    logic [9:0] idUs;
    logic [1:0] idRetry;
    logic restart;
    logic gotIdent;
    logic [7:0] divCnt;
    logic usTick;
    logic waitActive;
    logic waitScale;
    logic [14:0] waitCnt;
    logic [9:0] waitUs;
    logic rxActive;
    logic rxOver;
    logic [5:0] rxIdx;
    logic [255:0] rxBuf;
    logic identValid;
    ofi_pkg::ofi_ident_s ident;
    logic openValid;
    ofi_pkg::ofi_open_s openDec;
    logic reject;
    logic [15:0] tagLatest;
    logic asInit;
    logic phyDoneD;
  } ofi_state_s;

  ofi_state_s st_r;
  ofi_state_s st_nxt;

  // byte n of a frame buffer, byte 0 in the top bits
  function automatic logic [7:0] frameByte(input logic [255:0] buf_, input int n);
    frameByte = buf_[255 - 8 * n -: 8];
  endfunction

  function automatic logic [63:0] frameName(input logic [255:0] buf_, input int n);
    frameName = buf_[255 - 8 * n -: 64];
  endfunction

  // ****************************************************************
  // frame images
  // ****************************************************************
  logic [255:0] openImage;
  logic [255:0] identImage;
  logic [15:0] tagOut;

  always_comb begin
    if (tagFromInitiator) begin
      tagOut = tagLastRcvd;
    end else if (!tagNeeded) begin
      tagOut = `OFI_TAG_NONE;
    end else begin
      tagOut = tagForTarget;
    end
    openImage = '0;
    openImage[255 -: 8] = {openFields.initiator, 1'b0, openFields.protocol,
                           `OFI_AFT_OPEN};
    openImage[247 -: 8] = {4'h0, openFields.linkRate};
    openImage[239 -: 16] = tagOut;
    openImage[255 - 8 * `OFI_BYTE_WAIT -: 16] = {st_r.waitScale, st_r.waitCnt};
    openImage[255 - 8 * `OFI_BYTE_DEST -: 64] = openFields.destName;
    openImage[255 - 8 * `OFI_BYTE_SRC -: 64] = localIdent.devName;
    identImage = '0;
    identImage[255 -: 8] = {4'h0, `OFI_AFT_IDENTIFY};
    identImage[247 -: 8] = localIdent.phyId;
    identImage[239 -: 8] = {4'h0, localIdent.maxRate};
    identImage[231 -: 8] = localIdent.caps;
    identImage[255 - 8 * `OFI_BYTE_SRC -: 64] = localIdent.devName;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic rxDone;
    logic [7:0] b0;
    logic peerInit;
    logic identSet;
    rxDone = 1'b0;
    identSet = 1'b0;
    b0 = 8'h00;
    peerInit = 1'b0;
    st_nxt = st_r;
    st_nxt.openSent = 1'b0;
    st_nxt.identValid = 1'b0;
    st_nxt.openValid = 1'b0;
    st_nxt.reject = 1'b0;
    st_nxt.restart = 1'b0;
    st_nxt.phyDoneD = phyResetDone;

    // microsecond tick from the divider
    st_nxt.usTick = 1'b0;
    if (st_r.divCnt >= 8'(US_DIV_CNT - 1)) begin
      st_nxt.divCnt = 8'h00;
      st_nxt.usTick = 1'b1;
    end else begin
      st_nxt.divCnt = st_r.divCnt + 8'h01;
    end

    // arbitration wait time, saturating
    if (openReq && !st_r.openPend && !st_r.waitActive) begin
      st_nxt.waitActive = 1'b1;
      st_nxt.waitScale = 1'b0;
      st_nxt.waitCnt = '0;
      st_nxt.waitUs = '0;
    end else if (st_r.waitActive && st_r.usTick) begin
      if (!st_r.waitScale) begin
        if (st_r.waitCnt == `OFI_WAIT_MAX) begin
          st_nxt.waitScale = 1'b1;
          st_nxt.waitCnt = '0;
          st_nxt.waitUs = '0;
        end else begin
          st_nxt.waitCnt = st_r.waitCnt + 15'h0001;
        end
      end else if (st_r.waitUs == 10'(`OFI_US_PER_MS - 1)) begin
        st_nxt.waitUs = '0;
        if (st_r.waitCnt != `OFI_WAIT_MAX) begin
          st_nxt.waitCnt = st_r.waitCnt + 15'h0001;
        end
      end else begin
        st_nxt.waitUs = st_r.waitUs + 10'h001;
      end
    end

    // receive parser
    if (rxSoaf) begin
      st_nxt.rxActive = 1'b1;
      st_nxt.rxOver = 1'b0;
      st_nxt.rxIdx = '0;
    end else if (st_r.rxActive && rxValid) begin
      if (st_r.rxIdx < 6'(`OFI_FRAME_BYTES)) begin
        st_nxt.rxBuf[255 - 8 * st_r.rxIdx -: 8] = rxByte;
        st_nxt.rxIdx = st_r.rxIdx + 6'h01;
      end else begin
        st_nxt.rxOver = 1'b1;
      end
    end
    if (st_r.rxActive && rxEoaf) begin
      st_nxt.rxActive = 1'b0;
      rxDone = rxCrcOk && !st_r.rxOver && st_r.rxIdx == 6'(`OFI_FRAME_BYTES);
    end
    b0 = frameByte(st_r.rxBuf, `OFI_BYTE_TYPE);
    if (rxDone && b0[3:0] == `OFI_AFT_IDENTIFY) begin
      st_nxt.identValid = 1'b1;
      st_nxt.ident.phyId = frameByte(st_r.rxBuf, `OFI_BYTE_ID_PHY);
      st_nxt.ident.maxRate = st_r.rxBuf[251 - 8 * `OFI_BYTE_ID_RATE -: 4];
      st_nxt.ident.caps = frameByte(st_r.rxBuf, `OFI_BYTE_ID_CAPS);
      st_nxt.ident.devName = frameName(st_r.rxBuf, `OFI_BYTE_SRC);
      st_nxt.gotIdent = 1'b1;
      if (st_r.gotIdent) begin
        identSet = 1'b1;
      end
    end else if (rxDone && b0[3:0] == `OFI_AFT_OPEN && !connOpen) begin
      peerInit = b0[`OFI_BIT_INIT];
      st_nxt.openDec.initiator = peerInit;
      st_nxt.openDec.protocol = b0[5:4];
      st_nxt.openDec.linkRate = st_r.rxBuf[251 - 8 * `OFI_BYTE_RATE -: 4];
      st_nxt.openDec.connTag = {frameByte(st_r.rxBuf, `OFI_BYTE_TAG),
                                frameByte(st_r.rxBuf, `OFI_BYTE_TAG + 1)};
      st_nxt.openDec.scale = st_r.rxBuf[248 - 8 * `OFI_BYTE_WAIT + `OFI_BIT_SCALE];
      st_nxt.openDec.waitTime = st_r.rxBuf[254 - 8 * `OFI_BYTE_WAIT -: 15];
      st_nxt.openDec.destName = frameName(st_r.rxBuf, `OFI_BYTE_DEST);
      st_nxt.openDec.srcName = frameName(st_r.rxBuf, `OFI_BYTE_SRC);
      st_nxt.openValid = 1'b1;
      // tag kept as received, no cross
      if (peerInit) begin
        st_nxt.tagLatest = st_nxt.openDec.connTag;
      end
      st_nxt.reject = (peerInit && !roleTarget) || (!peerInit && !roleInitiator);
      if (!st_nxt.reject) begin
        st_nxt.asInit = !peerInit;
      end
    end

    // identification exchange
    if (!phyResetDone) begin
      st_nxt.idState = ofi_pkg::OFI_ID_OFF;
      st_nxt.gotIdent = 1'b0;
    end else begin
      unique case (st_r.idState)
        ofi_pkg::OFI_ID_OFF: begin
          if (!st_r.phyDoneD) begin
            st_nxt.idState = ofi_pkg::OFI_ID_WAIT;
            identSet = 1'b1;
            st_nxt.idUs = '0;
            st_nxt.idRetry = '0;
          end
        end
        ofi_pkg::OFI_ID_WAIT: begin
          if (st_nxt.identValid) begin
            st_nxt.idState = ofi_pkg::OFI_ID_DONE;
          end else if (st_r.usTick) begin
            if (st_r.idUs == 10'(ID_TIMEOUT_US - 1)) begin
              st_nxt.idUs = '0;
              if (st_r.idRetry == 2'(`OFI_ID_RETRIES)) begin
                st_nxt.idState = ofi_pkg::OFI_ID_FAIL;
                st_nxt.restart = 1'b1;
              end else begin
                st_nxt.idRetry = st_r.idRetry + 2'h1;
                identSet = 1'b1;
              end
            end else begin
              st_nxt.idUs = st_r.idUs + 10'h001;
            end
          end
        end
        ofi_pkg::OFI_ID_DONE: begin
        end
        ofi_pkg::OFI_ID_FAIL: begin
          if (st_nxt.identValid) begin
            st_nxt.idState = ofi_pkg::OFI_ID_DONE;
          end
        end
      endcase
    end

    // transmitter; identification takes precedence, none while connected
    unique case (st_r.txState)
      ofi_pkg::OFI_TX_IDLE: begin
        if (!connOpen && st_r.identPend) begin
          st_nxt.identPend = 1'b0;
          st_nxt.txBuf = identImage;
          st_nxt.txIsOpen = 1'b0;
          st_nxt.txState = ofi_pkg::OFI_TX_SOAF;
        end else if (!connOpen && st_r.openPend && st_r.idState == ofi_pkg::OFI_ID_DONE) begin
          st_nxt.txBuf = openImage;
          st_nxt.txIsOpen = 1'b1;
          st_nxt.asInit = openFields.initiator;
          st_nxt.txState = ofi_pkg::OFI_TX_SOAF;
        end
      end
      ofi_pkg::OFI_TX_SOAF: begin
        if (txReady) begin
          st_nxt.txIdx = '0;
          st_nxt.txState = ofi_pkg::OFI_TX_DATA;
        end
      end
      ofi_pkg::OFI_TX_DATA: begin
        if (txReady) begin
          st_nxt.txBuf = {st_r.txBuf[247:0], 8'h00};
          st_nxt.txIdx = st_r.txIdx + 5'h01;
          if (st_r.txIdx == 5'(`OFI_FRAME_BYTES - 1)) begin
            st_nxt.txState = ofi_pkg::OFI_TX_EOAF;
          end
        end
      end
      ofi_pkg::OFI_TX_EOAF: begin
        if (txReady) begin
          st_nxt.txState = ofi_pkg::OFI_TX_IDLE;
          if (st_r.txIsOpen) begin
            st_nxt.openPend = 1'b0;
            st_nxt.openSent = 1'b1;
            st_nxt.waitActive = 1'b0;
          end
        end
      end
      default: begin
        st_nxt.txState = ofi_pkg::OFI_TX_IDLE;
      end
    endcase

    // a new request wins over the clear of the one being taken
    if (identSet) begin
      st_nxt.identPend = 1'b1;
    end
    if (openReq) begin
      st_nxt.openPend = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs and port grouping
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < `OFI_NUM_PHYS; i++) begin
      samePortMask[i] = (i == PHY_INDEX) ||
                        (st_r.idState == ofi_pkg::OFI_ID_DONE && peerNamesValid[i] &&
                         peerNames[i] == st_r.ident.devName);
    end
  end

  assign txSoaf = st_r.txState == ofi_pkg::OFI_TX_SOAF;
  assign txEoaf = st_r.txState == ofi_pkg::OFI_TX_EOAF;
  assign txValid = st_r.txState == ofi_pkg::OFI_TX_DATA;
  assign txByte = st_r.txBuf[255:248];
  assign openBusy = st_r.openPend;
  assign openSent = st_r.openSent;
  assign rxIdentValid = st_r.identValid;
  assign rxIdent = st_r.ident;
  assign rxOpenValid = st_r.openValid;
  assign rxOpen = st_r.openDec;
  assign rejectProtocol = st_r.reject;
  assign rxTagLatest = st_r.tagLatest;
  assign connAsInitiator = st_r.asInit;
  assign identDone = st_r.idState == ofi_pkg::OFI_ID_DONE;
  assign phyResetRestart = st_r.restart;

endmodule

// ### verification/ofi_framer_props.sv
// ofi_framer_props.sv: port-level checks on the framer
// assumes: bound to ofi_framer, sees its ports only
`timescale 1ns/10ps
`include "ofi_map.svh"
module ofi_framer_props #(
  parameter int PHY_INDEX = 0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // roles and state
  input wire logic roleInitiator,
  input wire logic roleTarget,
  input wire logic connOpen,
  // transmit side
  input wire logic openSent,
  input wire logic txSoaf,
  input wire logic txEoaf,
  input wire logic txValid,
  input wire logic txReady,
  // receive side
  input wire logic rxEoaf,
  input wire logic rxCrcOk,
  input wire logic rxIdentValid,
  input wire ofi_pkg::ofi_ident_s rxIdent,
  input wire logic rxOpenValid,
  input wire ofi_pkg::ofi_open_s rxOpen,
  input wire logic rejectProtocol,
  input wire logic [15:0] rxTagLatest,
  // grouping
  input wire ofi_pkg::ofi_name_t [`OFI_NUM_PHYS-1:0] peerNames,
  input wire logic [`OFI_NUM_PHYS-1:0] peerNamesValid,
  input wire logic identDone,
  input wire logic [`OFI_NUM_PHYS-1:0] samePortMask
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_soaf_held: assert property (txSoaf && !txReady |=> txSoaf)
    else $error("start marker dropped before accept");
  a_eoaf_held: assert property (txEoaf && !txReady |=> txEoaf)
    else $error("end marker dropped before accept");
  a_marker_exclusive: assert property ($onehot0({txSoaf, txValid, txEoaf}))
    else $error("two frame markers at once");
  a_no_tx_conn: assert property ((connOpen && !txSoaf)[*2] |=> !txSoaf)
    else $error("frame started inside a connection");
  a_sent_after_eoaf: assert property (openSent |-> $past(txEoaf && txReady))
    else $error("request sent flag without end marker");
  a_ident_latency: assert property (rxIdentValid |-> $past(rxEoaf && rxCrcOk))
    else $error("identify flag without good frame end");
  a_open_latency: assert property (rxOpenValid |-> $past(rxEoaf && rxCrcOk))
    else $error("request flag without good frame end");
  a_reject_role: assert property (rxOpenValid |->
      rejectProtocol == (rxOpen.initiator ? !roleTarget : !roleInitiator))
    else $error("reject decision wrong");
  a_reject_alone: assert property (rejectProtocol |-> rxOpenValid)
    else $error("reject without request");
  a_tag_copy: assert property (rxOpenValid && rxOpen.initiator |->
      ##[0:1] rxTagLatest == rxOpen.connTag)
    else $error("latest tag not taken");
  a_own_bit: assert property (samePortMask[PHY_INDEX])
    else $error("own phy missing from port");
  a_group_match: assert property (samePortMask[1] == (identDone &&
      peerNamesValid[1] && peerNames[1] == rxIdent.devName))
    else $error("grouping of phy 1 wrong");
  c_ident: cover property (rxIdentValid);
  c_reject: cover property (rxOpenValid && rejectProtocol);
  c_sent: cover property (openSent);
endmodule

bind ofi_framer ofi_framer_props #(.PHY_INDEX(PHY_INDEX)) u_props (
  .clk(clk), .reset(reset), .roleInitiator(roleInitiator), .roleTarget(roleTarget),
  .connOpen(connOpen), .openSent(openSent), .txSoaf(txSoaf), .txEoaf(txEoaf),
  .txValid(txValid), .txReady(txReady), .rxEoaf(rxEoaf), .rxCrcOk(rxCrcOk),
  .rxIdentValid(rxIdentValid), .rxIdent(rxIdent), .rxOpenValid(rxOpenValid),
  .rxOpen(rxOpen), .rejectProtocol(rejectProtocol), .rxTagLatest(rxTagLatest),
  .peerNames(peerNames), .peerNamesValid(peerNamesValid), .identDone(identDone),
  .samePortMask(samePortMask));

// ### verification/ofi_link_peer.sv
// ofi_link_peer.sv: attached port seen through the link layer byte streams
// assumes: same clock as the framer; testbench calls send_frame
`timescale 1ns/10ps
module ofi_link_peer (
  // clock and pacing
  input wire logic clk,
  input wire logic slow,
  // frames from the framer
  input wire logic txValid,
  input wire logic txEoaf,
  input wire logic [7:0] txByte,
  output logic txReady,
  // frames to the framer
  output logic rxSoaf,
  output logic rxValid,
  output logic [7:0] rxByte,
  output logic rxEoaf,
  output logic rxCrcOk
);
  // ****
  // capture and send
  // ****
  logic [7:0] txFrame [32];
  int txCount = 0;
  int frameCount = 0;
  int lastLen = 0;
  initial begin
    txReady = 1'b1;
    rxSoaf = 1'b0;
    rxValid = 1'b0;
    rxByte = 8'h00;
    rxEoaf = 1'b0;
    rxCrcOk = 1'b0;
  end
  // slow pacing stalls every other cycle
  always @(posedge clk) begin
    txReady <= slow ? !txReady : 1'b1;
    if (txValid && txReady) begin
      if (txCount < 32) txFrame[txCount] <= txByte;
      txCount <= txCount + 1;
    end
    if (txEoaf && txReady) begin
      lastLen <= txCount;
      txCount <= 0;
      frameCount <= frameCount + 1;
    end
  end
  // start marker, n bytes, end marker with crc result
  task automatic send_frame(input logic [7:0] f [32], input int n, input logic crcOk);
    @(posedge clk);
    rxSoaf <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rxSoaf <= 1'b0;
      rxValid <= 1'b1;
      rxByte <= f[i];
    end
    @(posedge clk);
    rxValid <= 1'b0;
    rxByte <= ~rxByte;
    rxEoaf <= 1'b1;
    rxCrcOk <= crcOk;
    @(posedge clk);
    rxEoaf <= 1'b0;
    rxCrcOk <= 1'b0;
  endtask
endmodule

// ### verification/ofi_framer_tb.sv
// ofi_framer_tb.sv: self-checking bench for the framer
// assumes: short microsecond divider and timeout for a quick run
`timescale 1ns/10ps
`include "ofi_map.svh"
module ofi_framer_tb;
  // ****
  // stimulus and checks
  // ****
  localparam int US_DIV = 2;
  localparam int ID_TO = 100;
  localparam ofi_pkg::ofi_name_t PEER_A = 64'h5a01_0203_0405_06a7;
  localparam ofi_pkg::ofi_name_t PEER_B = 64'h7700_1100_2200_3300;
  logic clk = 1'b0;
  logic reset = 1'b1;
  ofi_pkg::ofi_ident_s localIdent = '{8'h03, 4'h1, 8'h0a, 64'h0123_4567_89ab_cdef};
  logic roleInitiator = 1'b1;
  logic roleTarget = 1'b1;
  logic phyResetDone = 1'b0;
  logic connOpen = 1'b0;
  logic openReq = 1'b0;
  ofi_pkg::ofi_open_s openFields = '0;
  logic tagNeeded = 1'b0;
  logic [15:0] tagForTarget = 16'h1234;
  logic tagFromInitiator = 1'b0;
  logic [15:0] tagLastRcvd = 16'h0bad;
  ofi_pkg::ofi_name_t [`OFI_NUM_PHYS-1:0] peerNames = '0;
  logic [`OFI_NUM_PHYS-1:0] peerNamesValid = '0;
  logic slow = 1'b0;
  logic openBusy, openSent, txSoaf, txEoaf, txValid, txReady, rxSoaf, rxValid;
  logic rxEoaf, rxCrcOk, rxIdentValid, rxOpenValid, rejectProtocol, connAsInitiator;
  logic identDone, phyResetRestart, lastReject;
  logic [7:0] txByte, rxByte;
  logic [15:0] rxTagLatest;
  logic [`OFI_NUM_PHYS-1:0] samePortMask;
  ofi_pkg::ofi_ident_s rxIdent;
  ofi_pkg::ofi_open_s rxOpen;
  logic [7:0] fr [32];
  int failCount = 0;
  int testsRun = 0;
  int identSeen = 0;
  int openSeen = 0;
  int sentSeen = 0;
  int restartSeen = 0;

  ofi_framer #(.US_DIV(US_DIV), .ID_TIMEOUT_US(ID_TO), .PHY_INDEX(0)) u_dut (
    .clk(clk), .reset(reset), .localIdent(localIdent), .roleInitiator(roleInitiator),
    .roleTarget(roleTarget), .phyResetDone(phyResetDone), .connOpen(connOpen),
    .openReq(openReq), .openFields(openFields), .tagNeeded(tagNeeded),
    .tagForTarget(tagForTarget), .tagFromInitiator(tagFromInitiator),
    .tagLastRcvd(tagLastRcvd), .openBusy(openBusy), .openSent(openSent), .txSoaf(txSoaf),
    .txEoaf(txEoaf), .txValid(txValid), .txByte(txByte), .txReady(txReady),
    .rxSoaf(rxSoaf), .rxValid(rxValid), .rxByte(rxByte), .rxEoaf(rxEoaf),
    .rxCrcOk(rxCrcOk), .rxIdentValid(rxIdentValid), .rxIdent(rxIdent),
    .rxOpenValid(rxOpenValid), .rxOpen(rxOpen), .rejectProtocol(rejectProtocol),
    .rxTagLatest(rxTagLatest), .connAsInitiator(connAsInitiator), .peerNames(peerNames),
    .peerNamesValid(peerNamesValid), .identDone(identDone),
    .phyResetRestart(phyResetRestart), .samePortMask(samePortMask));

  ofi_link_peer u_peer (
    .clk(clk), .slow(slow), .txValid(txValid), .txEoaf(txEoaf), .txByte(txByte),
    .txReady(txReady), .rxSoaf(rxSoaf), .rxValid(rxValid), .rxByte(rxByte),
    .rxEoaf(rxEoaf), .rxCrcOk(rxCrcOk));

  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (rxIdentValid) identSeen++;
    if (rxOpenValid) openSeen++;
    if (rxOpenValid) lastReject = rejectProtocol;
    if (openSent) sentSeen++;
    if (phyResetRestart) restartSeen++;
  end

  task automatic chk(input logic ok, input string msg);
    testsRun++;
    if (ok !== 1'b1) begin
      failCount++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task automatic wait_frame(input int lim, output logic got);
    int start;
    start = u_peer.frameCount;
    got = 1'b0;
    repeat (lim) begin
      @(posedge clk);
      if (u_peer.frameCount != start) got = 1'b1;
      if (got) break;
    end
  endtask
  function automatic ofi_pkg::ofi_name_t name_at(input int k);
    ofi_pkg::ofi_name_t v;
    v = '0;
    for (int i = 0; i < 8; i++) v = {v[55:0], u_peer.txFrame[k+i]};
    return v;
  endfunction
  task automatic build(input logic [7:0] b0, input ofi_pkg::ofi_name_t nm, input int k);
    for (int i = 0; i < 32; i++) fr[i] = 8'h00;
    fr[0] = b0;
    for (int i = 0; i < 8; i++) fr[k+i] = nm[63-8*i -: 8];
  endtask

  task automatic test_identify();
    logic got;
    @(posedge clk);
    phyResetDone <= 1'b1;
    wait_frame(100, got);
    chk(got && u_peer.txFrame[0][3:0] === 4'h0, "no identify sent");
    chk(u_peer.txFrame[1] === localIdent.phyId, "phy id");
    chk(name_at(20) === localIdent.devName, "own device name");
    build(8'h00, PEER_A, 20);
    u_peer.send_frame(fr, 32, 1'b1);
    repeat (3) @(posedge clk);
    chk(identSeen == 1 && rxIdent.devName === PEER_A, "peer identify");
    chk(identDone === 1'b1, "identify done");
    peerNames[1] <= PEER_A;
    peerNames[2] <= PEER_B;
    peerNamesValid <= 4'h6;
    repeat (2) @(posedge clk);
    #1;
    chk(samePortMask === 4'h3, "port grouping");
    u_peer.send_frame(fr, 32, 1'b1);
    wait_frame(150, got);
    chk(got && u_peer.txFrame[0][3:0] === 4'h0, "identify not resent");
  endtask

  task automatic test_open();
    logic got;
    logic [15:0] tag;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      slow <= i == 1;
      openFields.initiator <= i != 2;
      openFields.protocol <= i[1:0];
      openFields.linkRate <= {3'h0, i != 0};
      openFields.destName <= PEER_A;
      tagNeeded <= i == 1;
      tagFromInitiator <= i == 2;
      openReq <= 1'b1;
      @(posedge clk);
      openReq <= 1'b0;
      tag = i == 0 ? 16'hffff : (i == 1 ? 16'h1234 : 16'h0bad);
      wait_frame(200, got);
      repeat (2) @(posedge clk);
      chk(got && u_peer.lastLen == 32 && sentSeen == i + 1, "request frame");
      chk(u_peer.txFrame[0] === {i != 2, 1'b0, i[1:0], 4'h1}, "byte 0");
      chk(u_peer.txFrame[1][3:0] === {3'h0, i != 0}, "link rate");
      chk({u_peer.txFrame[2], u_peer.txFrame[3]} === tag, "tag");
      chk(u_peer.txFrame[10] === 8'h00 && u_peer.txFrame[11] < 8'h40, "wait time");
      chk(name_at(12) === PEER_A, "destination");
      chk(name_at(20) === localIdent.devName, "source");
    end
    slow <= 1'b0;
    chk(connAsInitiator === 1'b0, "role of sent request");
  endtask

  task automatic test_rx_open();
    int n;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      roleTarget <= i != 0;
      roleInitiator <= i != 2;
      n = openSeen;
      build({i == 0, 3'h1, 4'h1}, PEER_B, 20);
      fr[2] = 8'h43;
      fr[3] = 8'h21 + i[7:0];
      u_peer.send_frame(fr, 32, 1'b1);
      repeat (3) @(posedge clk);
      chk(openSeen == n + 1 && lastReject === (i != 1), "reject decision");
      chk(rxOpen.protocol === 2'h1 && rxOpen.srcName === PEER_B, "decode");
    end
    chk(rxTagLatest === 16'h4321 && connAsInitiator === 1'b1, "tag and role");
    roleTarget <= 1'b1;
    roleInitiator <= 1'b1;
    n = openSeen;
    for (int j = 0; j < 3; j++) begin
      build({4'h1, j == 1 ? 4'h2 : 4'h1}, PEER_B, 20);
      u_peer.send_frame(fr, j == 2 ? 31 : 32, j != 0);
    end
    repeat (3) @(posedge clk);
    chk(openSeen == n && identSeen == 2, "bad frames dropped");
  endtask

  task automatic test_conn_block();
    logic got;
    @(posedge clk);
    connOpen <= 1'b1;
    openReq <= 1'b1;
    @(posedge clk);
    openReq <= 1'b0;
    wait_frame(80, got);
    chk(got === 1'b0 && openBusy === 1'b1, "frame sent in connection");
    connOpen <= 1'b0;
    wait_frame(200, got);
    chk(got === 1'b1, "held request lost");
  endtask

  task automatic test_timeout();
    logic got;
    @(posedge clk);
    reset <= 1'b1;
    phyResetDone <= 1'b0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    phyResetDone <= 1'b1;
    wait_frame(100, got);
    wait_frame(ID_TO * US_DIV + 100, got);
    chk(got && u_peer.txFrame[0][3:0] === 4'h0, "no resend on timeout");
    repeat (ID_TO * US_DIV + 100) @(posedge clk);
    chk(restartSeen == 1, "no phy reset restart");
  endtask

  task automatic endOfTest();
    $display("checks %0d failures %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    $display("CHECK FAILED %0t watchdog", $time);
    endOfTest();
  end

  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk(identDone === 1'b0 && samePortMask === 4'h1 && txSoaf === 1'b0, "reset state");
    test_identify();
    test_open();
    test_rx_open();
    test_conn_block();
    test_timeout();
    endOfTest();
  end
endmodule
